/* rtl/dgmc_pkg.sv */
package dgmc_pkg;

    // register indices on the plain port
    localparam logic [3:0] PLAYBACK_GAIN_OFS = 4'h2;
    localparam logic [3:0] MIXER_GAIN_OFS = 4'h3;
    localparam logic [3:0] STEP_CTRL_OFS = 4'h4;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'h9;

    // playback register fields
    localparam int LEFT_MUTE_BIT = 15;
    localparam int LEFT_ATTEN_LSB = 8;
    localparam int RIGHT_MUTE_BIT = 7;
    localparam int RIGHT_ATTEN_LSB = 0;

    // mixer register fields
    localparam int SIDE_MUTE_BIT = 15;
    localparam int SIDE_GAIN_LSB = 8;
    localparam int SELECTOR_LSB = 5;
    localparam int ADC_CONNECT_BIT = 4;
    localparam int PHONE_ADC_BIT = 3;
    localparam int SIDE_FLAG_BIT = 0;

    // reset values and the sidetone gain clamp
    localparam logic [6:0] ATTEN_RESET = 7'h7F;
    localparam logic [6:0] SIDE_GAIN_RESET = 7'h45;
    localparam logic [6:0] SIDE_GAIN_CLAMP = 7'h5D;
    localparam logic [2:0] SELECTOR_RESET = 3'h0;

    // interrupt events: bit0 left settled, bit1 right settled, bit2 sidetone settled
    localparam int EVENT_COUNT = 3;

    // source select one-hot: headset, handset, aux one, aux two
    typedef enum logic [3:0] {
        DGMC_SRC_HEADSET = 4'h1,
        DGMC_SRC_HANDSET = 4'h2,
        DGMC_SRC_AUX_ONE = 4'h4,
        DGMC_SRC_AUX_TWO = 4'h8
    } dgmc_src_e;

    // stepper state
    typedef enum logic [1:0] {
        DGMC_IDLE = 2'h1,
        DGMC_STEP = 2'h2
    } dgmc_step_e;

endpackage

/* rtl/dgmc_gain_stepper.sv */
`timescale 1ns/1ps
`default_nettype none

// walks an applied 7-bit code toward a target, one step per enabled tick
module dgmc_gain_stepper
    import dgmc_pkg::*;
#(
    parameter logic [6:0] RESET_CODE = 7'h7F
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic stepTick,
    input wire logic [6:0] target,
    // status
    output logic [6:0] applied,
    output logic settled
);
    dgmc_step_e state;
    dgmc_step_e next_state;
    wire logic differ = (applied != target);
    wire logic goUp = (target > applied);
    wire logic [6:0] next_applied = goUp ? applied + 7'h01 : applied - 7'h01;

    always_comb
    begin
        case (state)
            DGMC_IDLE: next_state = differ ? DGMC_STEP : DGMC_IDLE;
            DGMC_STEP: next_state = differ ? DGMC_STEP : DGMC_IDLE;
            default: next_state = DGMC_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state <= DGMC_IDLE;
            applied <= RESET_CODE;
            settled <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == DGMC_STEP && differ && stepTick)
                applied <= next_applied;
            settled <= (applied == target);
        end
    end

    chk_step_single: assert property (@(posedge mclk) disable iff (srst) // RULE_13
        !stepTick |=> (applied == $past(applied)))
        else $error("applied code moved without a tick");
endmodule // dgmc_gain_stepper

`default_nettype wire

/* rtl/dac_gain_mixer_ctl.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: left playback mute bit silences left channel; resets to one.
// RULE_02: left attenuation 7-bit code, 0.5 dB steps, 0 to -63.5 dB; resets all ones.
// RULE_03: right playback mute bit silences right channel; resets to one.
// RULE_04: right attenuation separate 7-bit code, same scale; resets all ones.
// RULE_05: sidetone mute bit mutes the analog sidetone path; resets to one.
// RULE_06: sidetone gain linear from -34.5 dB, 0 dB at 1000101, clamped at 12 dB.
// RULE_07: selector codes 000..011 pick one single-ended source; resets to 000.
// RULE_08: selector codes 100..111 connect the four differential pairs in order.
// RULE_09: software must not rely on sidetone while differential input is chosen.
// RULE_10: connect bit routes the selected input to the ADC; resets to zero.
// RULE_11: phone bit connects the cellular phone input to the ADC; resets zero.
// RULE_12: read-only sidetone flag is one when applied gain equals setting.
// RULE_13: playback gain steps 0.5 dB per word clock, or per two when set.
// RULE_14: mixer bits 2..1 read zero; flag bit and reserved bits ignore writes.
module dac_gain_mixer_ctl
    import dgmc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // word clock tick, one cycle per sample period
    input wire logic wordTick,
    // playback controls
    output logic leftPlaybackMute,
    output logic [6:0] leftPlaybackAttenuation,
    output logic rightPlaybackMute,
    output logic [6:0] rightPlaybackAttenuation,
    // sidetone controls
    output logic sidetoneMute,
    output logic [6:0] sidetoneGain,
    // adc input switches, one-hot per source
    output logic [3:0] adcPositiveSource,
    output logic [3:0] adcNegativeSource,
    output logic adcDifferential,
    output logic phoneModuleToAdc,
    // interrupt
    output logic irq
);
    import dgmc_pkg::*;

    // programmed fields
    logic leftMute;
    logic [6:0] leftAtten;
    logic rightMute;
    logic [6:0] rightAtten;
    logic sideMute;
    logic [6:0] sideGainSet;
    logic [2:0] inputSelector;
    logic adcInputConnect;
    logic phoneAdc;
    logic stepRateControl;
    logic [EVENT_COUNT-1:0] irqStatus;
    logic [EVENT_COUNT-1:0] irqMask;
    logic stepHalf;

    // applied values and settled flags
    logic [6:0] leftApplied;
    logic [6:0] rightApplied;
    logic [6:0] sideApplied;
    logic leftSettled;
    logic rightSettled;
    logic sidetoneGainSettledFlag;
    logic [EVENT_COUNT-1:0] settledPrev;
    logic [1:0] eventArm;

    function automatic logic [3:0] srcOneHot(input logic [1:0] code);
        srcOneHot = 4'h1 << code;
    endfunction

    // address decode
    wire logic wrPlay = regWr && (regAddr == PLAYBACK_GAIN_OFS);
    wire logic wrMix = regWr && (regAddr == MIXER_GAIN_OFS);
    wire logic wrStep = regWr && (regAddr == STEP_CTRL_OFS);
    wire logic wrStat = regWr && (regAddr == IRQ_STATUS_OFS);
    wire logic wrMask = regWr && (regAddr == IRQ_MASK_OFS);

    // step pacing: playback every word clock, or every second one when the rate bit is set; sidetone every word clock
    wire logic playTick = wordTick && (!stepRateControl || stepHalf); // RULE_13
    wire logic sideTick = wordTick;

    // gain above 12 dB is clamped; soft-stepping aims at the clamped value
    wire logic [6:0] sideTarget = (sideGainSet > SIDE_GAIN_CLAMP) ? SIDE_GAIN_CLAMP
                                                                  : sideGainSet; // RULE_06

    wire logic [EVENT_COUNT-1:0] settledNow = {sidetoneGainSettledFlag, rightSettled,
                                               leftSettled};
    // settled flags leave reset low and rise once on their own; arming late hides that edge
    wire logic [EVENT_COUNT-1:0] settleRise = settledNow & ~settledPrev
                                              & {EVENT_COUNT{eventArm[1]}};

    wire logic [15:0] playWord = {leftMute, leftAtten, rightMute, rightAtten};
    // reserved bits 2..1 are held at zero on read
    wire logic [15:0] mixWord = {sideMute, sideGainSet, inputSelector, adcInputConnect,
                                 phoneAdc, 2'b00, sidetoneGainSettledFlag}; // RULE_14 RULE_12
    wire logic [15:0] stepWord = {15'h0000, stepRateControl};
    wire logic [15:0] statWord = {13'h0000, irqStatus};
    wire logic [15:0] maskWord = {13'h0000, irqMask};
    wire logic [15:0] next_rdata =
        (regAddr == PLAYBACK_GAIN_OFS) ? playWord :
        (regAddr == MIXER_GAIN_OFS) ? mixWord :
        (regAddr == STEP_CTRL_OFS) ? stepWord :
        (regAddr == IRQ_STATUS_OFS) ? statWord :
        (regAddr == IRQ_MASK_OFS) ? maskWord : 16'h0000;

    // input routing; diff codes pair a mic (selector bit 1) with an aux (selector bit 0)
    wire logic diffSel = inputSelector[2];
    wire logic [3:0] posSel = diffSel ? srcOneHot({1'b0, inputSelector[1]})
                                      : srcOneHot(inputSelector[1:0]); // RULE_07 RULE_08
    wire logic [3:0] negSel = diffSel ? srcOneHot({1'b1, inputSelector[0]})
                                      : 4'h0; // RULE_08
    wire logic [3:0] next_pos = adcInputConnect ? posSel : 4'h0; // RULE_10
    wire logic [3:0] next_neg = adcInputConnect ? negSel : 4'h0; // RULE_10

    // playback path: a muted channel outputs mute regardless of stepping
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            leftMute <= 1'b1;
            leftAtten <= ATTEN_RESET;
            rightMute <= 1'b1;
            rightAtten <= ATTEN_RESET;
        end
        else if (wrPlay)
        begin
            leftMute <= regWdata[LEFT_MUTE_BIT]; // RULE_01
            leftAtten <= regWdata[LEFT_ATTEN_LSB+:7]; // RULE_02
            rightMute <= regWdata[RIGHT_MUTE_BIT]; // RULE_03
            rightAtten <= regWdata[RIGHT_ATTEN_LSB+:7]; // RULE_04
        end
    end

    // flag and reserved bits are not stored, so writes there have no effect
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sideMute <= 1'b1;
            sideGainSet <= SIDE_GAIN_RESET;
            inputSelector <= SELECTOR_RESET;
            adcInputConnect <= 1'b0;
            phoneAdc <= 1'b0;
        end
        else if (wrMix)
        begin
            sideMute <= regWdata[SIDE_MUTE_BIT]; // RULE_05
            sideGainSet <= regWdata[SIDE_GAIN_LSB+:7]; // RULE_06
            inputSelector <= regWdata[SELECTOR_LSB+:3]; // RULE_07
            adcInputConnect <= regWdata[ADC_CONNECT_BIT]; // RULE_10
            phoneAdc <= regWdata[PHONE_ADC_BIT]; // RULE_11
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            stepRateControl <= 1'b0;
            stepHalf <= 1'b0;
            irqMask <= '0;
        end
        else
        begin
            if (wrStep)
                stepRateControl <= regWdata[0];
            if (wrMask)
                irqMask <= regWdata[EVENT_COUNT-1:0];
            if (wordTick)
                stepHalf <= !stepHalf;
        end
    end

    // sticky events: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            irqStatus <= '0;
            settledPrev <= '0;
            eventArm <= 2'b00;
        end
        else
        begin
            settledPrev <= settledNow;
            eventArm <= {eventArm[0], 1'b1};
            irqStatus <= (irqStatus & ~(wrStat ? regWdata[EVENT_COUNT-1:0] : '0))
                         | settleRise;
        end
    end

    dgmc_gain_stepper #(.RESET_CODE(ATTEN_RESET)) leftStepper (
        .mclk(mclk), .srst(srst), .stepTick(playTick), .target(leftAtten),
        .applied(leftApplied), .settled(leftSettled)); // RULE_13
    dgmc_gain_stepper #(.RESET_CODE(ATTEN_RESET)) rightStepper (
        .mclk(mclk), .srst(srst), .stepTick(playTick), .target(rightAtten),
        .applied(rightApplied), .settled(rightSettled)); // RULE_13
    dgmc_gain_stepper #(.RESET_CODE(SIDE_GAIN_RESET)) sideStepper (
        .mclk(mclk), .srst(srst), .stepTick(sideTick), .target(sideTarget),
        .applied(sideApplied), .settled(sidetoneGainSettledFlag)); // RULE_12

    // outputs, all registered
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            regRdata <= 16'h0000;
            leftPlaybackMute <= 1'b1;
            leftPlaybackAttenuation <= ATTEN_RESET;
            rightPlaybackMute <= 1'b1;
            rightPlaybackAttenuation <= ATTEN_RESET;
            sidetoneMute <= 1'b1;
            sidetoneGain <= SIDE_GAIN_RESET;
            adcPositiveSource <= 4'h0;
            adcNegativeSource <= 4'h0;
            adcDifferential <= 1'b0;
            phoneModuleToAdc <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            regRdata <= regRd ? next_rdata : 16'h0000;
            leftPlaybackMute <= leftMute; // RULE_01
            leftPlaybackAttenuation <= leftApplied; // RULE_02
            rightPlaybackMute <= rightMute; // RULE_03
            rightPlaybackAttenuation <= rightApplied; // RULE_04
            // sidetone is meaningless on differential inputs; software must keep it muted
            sidetoneMute <= sideMute; // RULE_05 RULE_09
            sidetoneGain <= sideApplied; // RULE_06
            adcPositiveSource <= next_pos;
            adcNegativeSource <= next_neg;
            adcDifferential <= adcInputConnect && diffSel; // RULE_08
            phoneModuleToAdc <= phoneAdc; // RULE_11
            irq <= |(irqStatus & irqMask);
        end
    end

    sequence mixWrite;
        wrMix;
    endsequence

    chk_left_mute: assert property (@(posedge mclk) disable iff (srst) // RULE_01
        wrPlay ##1 1 |=> leftPlaybackMute == $past(regWdata[LEFT_MUTE_BIT], 2))
        else $error("left mute output does not follow write");
    chk_right_mute: assert property (@(posedge mclk) disable iff (srst) // RULE_03
        wrPlay ##1 1 |=> rightPlaybackMute == $past(regWdata[RIGHT_MUTE_BIT], 2))
        else $error("right mute output does not follow write");
    chk_side_mute: assert property (@(posedge mclk) disable iff (srst) // RULE_05
        mixWrite ##1 1 |=> sidetoneMute == $past(regWdata[SIDE_MUTE_BIT], 2))
        else $error("sidetone mute output does not follow write");
    chk_side_clamp: assert property (@(posedge mclk) disable iff (srst) // RULE_06
        sidetoneGain <= SIDE_GAIN_CLAMP)
        else $error("sidetone gain above clamp");
    chk_side_step: assert property (@(posedge mclk) disable iff (srst) // RULE_12
        sideApplied != $past(sideApplied) |->
        sideApplied - $past(sideApplied) == 7'h01 ||
        $past(sideApplied) - sideApplied == 7'h01)
        else $error("sidetone code moved by more than one step");
    chk_adc_off: assert property (@(posedge mclk) disable iff (srst) // RULE_10
        !adcInputConnect ##1 !adcInputConnect |=> adcPositiveSource == 4'h0)
        else $error("source connected while switch open");
    chk_adc_connect: assert property (@(posedge mclk) disable iff (srst) // RULE_10
        adcPositiveSource != 4'h0 |-> $past(adcInputConnect))
        else $error("source shown without a closed switch");
    chk_single_ended: assert property (@(posedge mclk) disable iff (srst) // RULE_07
        $stable(inputSelector) && !diffSel && adcInputConnect |=>
        adcNegativeSource == 4'h0 || $past(diffSel, 2))
        else $error("negative leg driven in single-ended mode");
    chk_diff_pair: assert property (@(posedge mclk) disable iff (srst) // RULE_08
        adcDifferential |-> adcNegativeSource[3:2] != 2'b00
                            && adcPositiveSource[1:0] != 2'b00)
        else $error("differential pair wrong");
    chk_phone_adc: assert property (@(posedge mclk) disable iff (srst) // RULE_11
        mixWrite |=> ##1 phoneModuleToAdc == $past(regWdata[PHONE_ADC_BIT], 2))
        else $error("phone switch does not follow write");
    chk_flag_meaning: assert property (@(posedge mclk) disable iff (srst) // RULE_12
        sidetoneGainSettledFlag |-> $past(sideApplied == sideTarget))
        else $error("settled flag set while gains differ");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (srst) // RULE_14
        $past(regRd) && $past(regAddr) == MIXER_GAIN_OFS |-> regRdata[2:1] == 2'b00)
        else $error("reserved bits read nonzero");
    chk_left_toward: assert property (@(posedge mclk) disable iff (srst) // RULE_02
        leftApplied > $past(leftApplied) |-> $past(leftAtten) > $past(leftApplied))
        else $error("left code stepped away from its setting");
    chk_left_step: assert property (@(posedge mclk) disable iff (srst) // RULE_13
        leftApplied != $past(leftApplied) |->
        leftApplied - $past(leftApplied) == 7'h01 ||
        $past(leftApplied) - leftApplied == 7'h01)
        else $error("left code moved by more than one step");
    chk_right_step: assert property (@(posedge mclk) disable iff (srst) // RULE_13
        rightApplied != $past(rightApplied) |->
        rightApplied - $past(rightApplied) == 7'h01 ||
        $past(rightApplied) - rightApplied == 7'h01)
        else $error("right code moved by more than one step");
    chk_step_rate: assert property (@(posedge mclk) disable iff (srst) // RULE_13
        wordTick && stepRateControl && !stepHalf |=> $stable(leftApplied))
        else $error("step taken on skipped word clock");
endmodule // dac_gain_mixer_ctl

`default_nettype wire

/* test/dgmc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// software side of the register port; one access per call, never overlapping
module dgmc_host_model
    import dgmc_pkg::*;
(
    // clock
    input wire logic mclk,
    // register port
    output logic [3:0] regAddr,
    output logic [15:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [15:0] regRdata
);
    initial
    begin
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    task automatic writeReg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        // stale data left on the bus would hide a missing strobe qualifier
        regWdata <= ~d;
    endtask

    // data stand only in the cycle after the strobe, so take them at that edge
    task automatic readReg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(posedge mclk);
        d = regRdata;
    endtask
endmodule // dgmc_host_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import dgmc_pkg::*;
    typedef struct {logic [2:0] sel; logic [3:0] pos; logic [3:0] neg;} dgmc_row_s;
    logic mclk, srst, wordTick, regWr, regRd, lMute, rMute, sMute, adcDiff, phone, irq;
    logic [3:0] regAddr, pos, neg;
    logic [15:0] regWdata, regRdata, rd;
    logic [6:0] lAtt, rAtt, sGain, prevLeft;
    int n_fail = 0;
    int comparisons = 0;
    int tickCnt = 0;
    int badStep = 0;
    int sinceChange = 0;
    int stepGap = 0;
    dgmc_row_s rows [8] = '{'{3'h0, 4'h1, 4'h0}, '{3'h1, 4'h2, 4'h0}, '{3'h2, 4'h4, 4'h0},
        '{3'h3, 4'h8, 4'h0}, '{3'h4, 4'h1, 4'h4}, '{3'h5, 4'h1, 4'h8},
        '{3'h6, 4'h2, 4'h4}, '{3'h7, 4'h2, 4'h8}};

    dac_gain_mixer_ctl dut (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .wordTick(wordTick),
        .leftPlaybackMute(lMute), .leftPlaybackAttenuation(lAtt), .rightPlaybackMute(rMute),
        .rightPlaybackAttenuation(rAtt), .sidetoneMute(sMute), .sidetoneGain(sGain),
        .adcPositiveSource(pos), .adcNegativeSource(neg), .adcDifferential(adcDiff),
        .phoneModuleToAdc(phone), .irq(irq));

    dgmc_host_model host (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // word clock every fourth cycle
    always @(posedge mclk)
    begin
        tickCnt <= (tickCnt + 1) % 4;
        wordTick <= (tickCnt == 3);
    end

    // every change of the applied left code must be one step; the gap before the latest change is kept for the step rate check
    always @(posedge mclk)
    begin
        sinceChange++;
        if (lAtt != prevLeft)
        begin
            stepGap = sinceChange;
            sinceChange = 0;
            if (lAtt + 7'h01 != prevLeft && prevLeft + 7'h01 != lAtt)
                badStep++;
        end
        prevLeft = lAtt;
    end

    task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkReg(input logic [3:0] a, input logic [15:0] exp);
        host.readReg(a, rd);
        compare(rd, exp, "register read");
    endtask

    task automatic chkPin(input logic [15:0] got, input logic [15:0] exp);
        compare(got, exp, "output pin");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #300us;
        n_fail++;
        end_of_test;
    end

    initial
    begin
        srst = 1'b1;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        chkPin(16'(lMute), 16'h0001);
        chkPin(16'(rMute), 16'h0001);
        chkPin(16'(sMute), 16'h0001);
        chkPin({pos, neg, 8'(phone)}, 16'h0000);
        chkReg(PLAYBACK_GAIN_OFS, 16'hFFFF);
        chkReg(MIXER_GAIN_OFS, 16'hC501);
        chkReg(4'h5, 16'h0000);
        chkReg(IRQ_MASK_OFS, 16'h0000);
        // flags settling out of reset must not count as events
        chkReg(IRQ_STATUS_OFS, 16'h0000);
        host.writeReg(IRQ_STATUS_OFS, 16'h0007);
        chkReg(IRQ_STATUS_OFS, 16'h0000);
        // every selector code, reserved and flag bits written as ones
        foreach (rows[i])
        begin
            host.writeReg(MIXER_GAIN_OFS, {1'b0, 7'h45, rows[i].sel, 1'b1, rows[i].sel[0], 3'h7});
            chkReg(MIXER_GAIN_OFS, {1'b0, 7'h45, rows[i].sel, 1'b1, rows[i].sel[0], 3'h1});
            chkPin(16'(pos), 16'(rows[i].pos));
            chkPin(16'(neg), 16'(rows[i].neg));
            chkPin(16'(adcDiff), 16'(rows[i].sel[2]));
            chkPin(16'(phone), 16'(rows[i].sel[0]));
            chkPin(16'(sMute), 16'h0000);
        end
        host.writeReg(MIXER_GAIN_OFS, 16'h4588);
        repeat (3) @(posedge mclk);
        chkPin({pos, neg, 7'h00, adcDiff}, 16'h0000);
        chkPin(16'(phone), 16'h0001);
        // full ramp down at one step per word clock
        host.writeReg(IRQ_MASK_OFS, 16'h0001);
        host.writeReg(PLAYBACK_GAIN_OFS, 16'h0000);
        repeat (3) @(posedge mclk);
        chkPin({7'h00, lMute, 7'h00, rMute}, 16'h0000);
        chkPin(16'(irq), 16'h0000);
        repeat (600) @(posedge mclk);
        chkPin({1'b0, lAtt, 1'b0, rAtt}, 16'h0000);
        chkPin(16'(stepGap), 16'd4);
        chkReg(IRQ_STATUS_OFS, 16'h0003);
        chkPin(16'(irq), 16'h0001);
        host.writeReg(IRQ_STATUS_OFS, 16'h0003);
        repeat (3) @(posedge mclk);
        chkPin(16'(irq), 16'h0000);
        // slow step rate, full ramp back up
        host.writeReg(STEP_CTRL_OFS, 16'h0001);
        chkReg(STEP_CTRL_OFS, 16'h0001);
        host.writeReg(PLAYBACK_GAIN_OFS, 16'h7F7F);
        repeat (1100) @(posedge mclk);
        chkPin({1'b0, lAtt, 1'b0, rAtt}, 16'h7F7F);
        chkPin(16'(stepGap), 16'd8);
        chkPin(16'(badStep), 16'h0000);
        // sidetone above the clamp, single-ended source so the path is valid
        host.writeReg(IRQ_MASK_OFS, 16'h0004);
        host.writeReg(MIXER_GAIN_OFS, 16'h7F01);
        chkReg(MIXER_GAIN_OFS, 16'h7F00);
        repeat (200) @(posedge mclk);
        chkPin(16'(sGain), 16'h005D);
        chkReg(MIXER_GAIN_OFS, 16'h7F01);
        chkPin(16'(irq), 16'h0001);
        // reset in mid-run: fields return to reset values with no spurious event
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        chkPin({7'h00, lMute, 7'h00, rMute}, 16'h0101);
        chkPin(16'(sGain), 16'h0045);
        chkReg(MIXER_GAIN_OFS, 16'hC501);
        chkReg(IRQ_STATUS_OFS, 16'h0000);
        chkPin(16'(irq), 16'h0000);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
